// ==== common/lpc_pkg.sv ====
package lpc_pkg;

   // Byte addresses of the registers, low address byte only
   localparam logic [7:0]  ADDR_CTRL      = 8'h00;
   localparam logic [7:0]  ADDR_IRQ_STAT  = 8'h04;
   localparam logic [7:0]  ADDR_IRQ_MASK  = 8'h08;
   localparam logic [7:0]  ADDR_STATE     = 8'h0c;

   // Control and status register fields
   localparam int unsigned BIT_OT_IE      = 7;
   localparam int unsigned BIT_OTC        = 6;
   localparam int unsigned BIT_RX         = 5;
   localparam int unsigned BIT_TX_FORCE   = 4;
   localparam int unsigned BIT_UNDERVOLTAGE_SHUTDOWN_DISABLE       = 3;
   localparam int unsigned BIT_EN         = 2;
   localparam int unsigned SLEW_LSB       = 0;
   localparam int unsigned SLEW_W         = 2;

   // Slew rate codes
   localparam logic [1:0]  SLEW_NORMAL    = 2'h0;
   localparam logic [1:0]  SLEW_SLOW      = 2'h1;
   localparam logic [1:0]  SLEW_FAST      = 2'h2;
   localparam logic [1:0]  SLEW_NORMAL_B  = 2'h3;

   // Reset values
   localparam logic [1:0]  SLEW_RST       = SLEW_NORMAL;
   localparam logic        OT_IE_RST      = 1'h0;
   localparam logic        TX_FORCE_RST   = 1'h0;
   localparam logic        UNDERVOLTAGE_SHUTDOWN_DISABLE_RST       = 1'h0;
   localparam logic        EN_RST         = 1'h0;

   // Interrupt status and mask layout
   localparam int unsigned EV_W           = 3;
   localparam int unsigned EV_OT          = 0;
   localparam int unsigned EV_UV          = 1;
   localparam int unsigned EV_TX_BACK     = 2;
   localparam logic [2:0]  IRQ_STAT_RST   = 3'h0;
   localparam logic [2:0]  IRQ_MASK_RST   = 3'h0;

   // Internal state register layout
   localparam int unsigned ST_OT_SHUT     = 0;
   localparam int unsigned ST_UV_HOLD     = 1;
   localparam int unsigned ST_DRIVE       = 2;
   localparam int unsigned ST_TXD         = 3;

   // Synchronised pins: {undervoltage, overtemp, rx}
   localparam int unsigned PIN_W          = 3;
   localparam int unsigned PIN_RX         = 0;
   localparam int unsigned PIN_OT         = 1;
   localparam int unsigned PIN_UV         = 2;
   localparam logic [2:0]  PIN_RST        = 3'h1;

   typedef enum logic [2:0] {
      BUS_IDLE = 3'b001,
      BUS_WAIT = 3'b010,
      BUS_DONE = 3'b100
   } lpc_bus_e;

endpackage : lpc_pkg

// ==== common/lpc_reg_if.sv ====
`timescale 1ns/1ps
interface lpc_reg_if;
   logic        wr_en;
   logic        rd_en;
   logic [7:0]  addr;
   logic [31:0] wdata;
   logic [31:0] rdata;

   modport bus  (output wr_en, output rd_en, output addr, output wdata, input rdata);
   modport core (input wr_en, input rd_en, input addr, input wdata, output rdata);
endinterface : lpc_reg_if

// ==== hw/lpc_ahb_slave.sv ====
`timescale 1ns/1ps
module lpc_ahb_slave (
   input  wire logic        sys_clk,
   input  wire logic        rst_sync_n,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic [31:0]      hrdata,
   lpc_reg_if.bus           regs
);

   lpc_pkg::lpc_bus_e st_r;
   logic [7:0]        addr_r;
   logic              write_r;
   logic [31:0]       hrdata_r;
   logic              take;

   // NONSEQ or SEQ both start a transfer; only singles are expected
   assign take = hsel & htrans[1] & hready;

   always_ff @(posedge sys_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         st_r <= lpc_pkg::BUS_IDLE;
      end else begin
         unique case (st_r)
            lpc_pkg::BUS_IDLE: begin
               if (take) st_r <= lpc_pkg::BUS_WAIT;
            end
            lpc_pkg::BUS_WAIT: begin
               st_r <= lpc_pkg::BUS_DONE;
            end
            lpc_pkg::BUS_DONE: begin
               st_r <= take ? lpc_pkg::BUS_WAIT : lpc_pkg::BUS_IDLE;
            end
            default: begin
               st_r <= lpc_pkg::BUS_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge sys_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         addr_r  <= 8'h00;
         write_r <= 1'b0;
      end else if (take) begin
         addr_r  <= haddr[7:0];
         write_r <= hwrite;
      end
   end

   // One wait state lets read data come from a flip-flop
   assign regs.addr  = addr_r;
   assign regs.wdata = hwdata;
   assign regs.wr_en = (st_r == lpc_pkg::BUS_WAIT) & write_r;
   assign regs.rd_en = (st_r == lpc_pkg::BUS_WAIT) & ~write_r;

   always_ff @(posedge sys_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         hrdata_r <= 32'h0000_0000;
      end else if (regs.rd_en) begin
         hrdata_r <= regs.rdata;
      end
   end

   assign hrdata    = hrdata_r;
   assign hreadyout = (st_r != lpc_pkg::BUS_WAIT);
   assign hresp     = 1'b0;

endmodule : lpc_ahb_slave

// ==== hw/lpc_top.sv ====
`timescale 1ns/1ps
// How it works
// - Control bit 7 enables the over-temperature interrupt request.
// - Bit 6 reads one during over-temperature; the driver is shut down then.
// - Reading the condition bit clears the pending over-temperature flag.
// - Bit 5 shows live bus level: 0 dominant, 1 recessive.
// - Bit 4 set forces the transmitter dominant, ORed with the transmit path.
// - Bit 3 clear forces recessive on supply under-voltage; set keeps bus working.
// - Bit 2 enables the physical layer; clear disables it.
// - Bits 1:0 pick slew: 00 normal, 01 slow, 10 fast, 11 normal.
// - A new over-temperature interrupt needs the condition to vanish and recur.
// - Shut driver re-enables once over-temperature is gone and transmit input high.
// - Under-voltage while dominant waits for the next release, then holds recessive.
// - Slew selection resets to normal.
module lpc_top (
   input  wire logic        sys_clk,
   input  wire logic        rst_n,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic [31:0]      hrdata,
   input  wire logic        txd_in,
   input  wire logic        rx_pin,
   input  wire logic        overtemp_pin,
   input  wire logic        undervoltage_pin,
   output logic             lin_drive_dominant,
   output logic             phy_enable,
   output logic [1:0]       slew_mode,
   output logic             irq
);

   function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
      hit = (a == off);
   endfunction : hit

   function automatic logic [1:0] norm_slew(input logic [1:0] code);
      norm_slew = (code == lpc_pkg::SLEW_NORMAL_B) ? lpc_pkg::SLEW_NORMAL : code;
   endfunction : norm_slew

   logic                     rst_s1_r;
   logic                     rst_sync_n;
   logic [lpc_pkg::PIN_W-1:0] pin_s1_r;
   logic [lpc_pkg::PIN_W-1:0] pin_s2_r;
   logic                     ot_prev_r;
   logic                     uv_prev_r;
   logic                     ot_ie_r;
   logic                     tx_force_r;
   logic                     undervoltage_shutdown_disable_r;
   logic                     en_r;
   logic [1:0]               slew_r;
   logic                     ot_shut_r;
   logic                     uv_hold_r;
   logic                     drive_r;
   logic [1:0]               slew_mode_r;
   logic [lpc_pkg::EV_W-1:0] stat_r;
   logic [lpc_pkg::EV_W-1:0] stat_nxt;
   logic [lpc_pkg::EV_W-1:0] mask_r;
   logic [lpc_pkg::EV_W-1:0] ev;
   logic [lpc_pkg::EV_W-1:0] clr;
   logic                     irq_r;
   logic                     rx_now;
   logic                     ot_now;
   logic                     uv_now;
   logic                     tx_req;
   logic                     uv_act;
   logic                     wr_ctrl;
   logic [7:0]               ctrl_rd;

   lpc_reg_if regs ();

   lpc_ahb_slave u_slave (
      .sys_clk    (sys_clk),
      .rst_sync_n (rst_sync_n),
      .hsel       (hsel),
      .haddr      (haddr),
      .htrans     (htrans),
      .hwrite     (hwrite),
      .hwdata     (hwdata),
      .hready     (hready),
      .hreadyout  (hreadyout),
      .hresp      (hresp),
      .hrdata     (hrdata),
      .regs       (regs)
   );

   // Reset release is synchronised; assertion stays asynchronous
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         rst_s1_r <= 1'b0;
      end else begin
         rst_s1_r <= 1'b1;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         rst_sync_n <= 1'b0;
      end else begin
         rst_sync_n <= rst_s1_r;
      end
   end

   // Analog comparator pins are asynchronous
   always_ff @(posedge sys_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         pin_s1_r <= lpc_pkg::PIN_RST;
         pin_s2_r <= lpc_pkg::PIN_RST;
      end else begin
         pin_s1_r <= {undervoltage_pin, overtemp_pin, rx_pin};
         pin_s2_r <= pin_s1_r;
      end
   end

   assign rx_now = pin_s2_r[lpc_pkg::PIN_RX];
   assign ot_now = pin_s2_r[lpc_pkg::PIN_OT];
   assign uv_now = pin_s2_r[lpc_pkg::PIN_UV];

   // Edge detectors start at the idle level, so reset gives no false edge
   always_ff @(posedge sys_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         ot_prev_r <= 1'b0;
      end else begin
         ot_prev_r <= ot_now;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         uv_prev_r <= 1'b0;
      end else begin
         uv_prev_r <= uv_now;
      end
   end

   assign wr_ctrl = regs.wr_en & hit(regs.addr, lpc_pkg::ADDR_CTRL);

   // Control register; bits 6 and 5 have no storage
   always_ff @(posedge sys_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         ot_ie_r <= lpc_pkg::OT_IE_RST;
      end else if (wr_ctrl) begin
         ot_ie_r <= regs.wdata[lpc_pkg::BIT_OT_IE];
      end
   end

   // Force stays set across a shutdown, so the bus goes dominant again on recovery
   always_ff @(posedge sys_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         tx_force_r <= lpc_pkg::TX_FORCE_RST;
      end else if (wr_ctrl) begin
         tx_force_r <= regs.wdata[lpc_pkg::BIT_TX_FORCE];
      end
   end

   always_ff @(posedge sys_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         undervoltage_shutdown_disable_r <= lpc_pkg::UNDERVOLTAGE_SHUTDOWN_DISABLE_RST;
      end else if (wr_ctrl) begin
         undervoltage_shutdown_disable_r <= regs.wdata[lpc_pkg::BIT_UNDERVOLTAGE_SHUTDOWN_DISABLE];
      end
   end

   // Clearing the enable drops the request at once, even in mid-bit
   always_ff @(posedge sys_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         en_r <= lpc_pkg::EN_RST;
      end else if (wr_ctrl) begin
         en_r <= regs.wdata[lpc_pkg::BIT_EN];
      end
   end

   always_ff @(posedge sys_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         slew_r <= lpc_pkg::SLEW_RST;
      end else if (wr_ctrl) begin
         slew_r <= regs.wdata[lpc_pkg::SLEW_LSB +: lpc_pkg::SLEW_W];
      end
   end

   // Transmit request: inverted transmit input ORed with the force bit
   assign tx_req = en_r & (~txd_in | tx_force_r);
   assign uv_act = uv_now & ~undervoltage_shutdown_disable_r;

   // Over-temperature shutdown latch
   always_ff @(posedge sys_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         ot_shut_r <= 1'b0;
      end else if (ot_now) begin
         ot_shut_r <= 1'b1;
      end else if (txd_in) begin
         ot_shut_r <= 1'b0;
      end
   end

   // Hold only changes while the request is recessive, so no dominant bit is cut short
   always_ff @(posedge sys_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         uv_hold_r <= 1'b0;
      end else if (!tx_req) begin
         uv_hold_r <= uv_act;
      end
   end

   // Registered so the pin never glitches while the inputs settle
   always_ff @(posedge sys_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         drive_r <= 1'b0;
      end else begin
         drive_r <= tx_req & ~ot_shut_r & ~uv_hold_r;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         slew_mode_r <= lpc_pkg::SLEW_RST;
      end else begin
         slew_mode_r <= norm_slew(slew_r);
      end
   end

   assign lin_drive_dominant = drive_r;
   assign phy_enable         = en_r;
   assign slew_mode          = slew_mode_r;

   // Over-temperature event only on a fresh rising edge of the condition
   assign ev[lpc_pkg::EV_OT]      = ot_now & ~ot_prev_r & ot_ie_r;
   assign ev[lpc_pkg::EV_UV]      = uv_now & ~uv_prev_r;
   assign ev[lpc_pkg::EV_TX_BACK] = ot_shut_r & ~ot_now & txd_in;

   // Write one to clear; a read of the control register also acknowledges over-temperature
   always_comb begin
      clr = '0;
      if (regs.wr_en && hit(regs.addr, lpc_pkg::ADDR_IRQ_STAT)) begin
         clr = regs.wdata[lpc_pkg::EV_W-1:0];
      end
      if (regs.rd_en && hit(regs.addr, lpc_pkg::ADDR_CTRL)) begin
         clr[lpc_pkg::EV_OT] = 1'b1;
      end
   end

   // Set wins over clear in the same cycle
   assign stat_nxt = (stat_r & ~clr) | ev;

   always_ff @(posedge sys_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         stat_r <= lpc_pkg::IRQ_STAT_RST;
      end else begin
         stat_r <= stat_nxt;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         mask_r <= lpc_pkg::IRQ_MASK_RST;
      end else if (regs.wr_en && hit(regs.addr, lpc_pkg::ADDR_IRQ_MASK)) begin
         mask_r <= regs.wdata[lpc_pkg::EV_W-1:0];
      end
   end

   always_ff @(posedge sys_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         irq_r <= 1'b0;
      end else begin
         irq_r <= |(stat_r & mask_r);
      end
   end

   assign irq = irq_r;

   always_comb begin
      ctrl_rd                                         = 8'h00;
      ctrl_rd[lpc_pkg::BIT_OT_IE]                     = ot_ie_r;
      ctrl_rd[lpc_pkg::BIT_OTC]                       = ot_now;
      ctrl_rd[lpc_pkg::BIT_RX]                        = rx_now;
      ctrl_rd[lpc_pkg::BIT_TX_FORCE]                  = tx_force_r;
      ctrl_rd[lpc_pkg::BIT_UNDERVOLTAGE_SHUTDOWN_DISABLE]                      = undervoltage_shutdown_disable_r;
      ctrl_rd[lpc_pkg::BIT_EN]                        = en_r;
      ctrl_rd[lpc_pkg::SLEW_LSB +: lpc_pkg::SLEW_W]   = slew_r;
   end

   // Unmapped addresses read zero and ignore writes
   always_comb begin
      regs.rdata = 32'h0000_0000;
      if (hit(regs.addr, lpc_pkg::ADDR_CTRL)) begin
         regs.rdata[7:0] = ctrl_rd;
      end else if (hit(regs.addr, lpc_pkg::ADDR_IRQ_STAT)) begin
         regs.rdata[lpc_pkg::EV_W-1:0] = stat_r;
      end else if (hit(regs.addr, lpc_pkg::ADDR_IRQ_MASK)) begin
         regs.rdata[lpc_pkg::EV_W-1:0] = mask_r;
      end else if (hit(regs.addr, lpc_pkg::ADDR_STATE)) begin
         regs.rdata[lpc_pkg::ST_OT_SHUT] = ot_shut_r;
         regs.rdata[lpc_pkg::ST_UV_HOLD] = uv_hold_r;
         regs.rdata[lpc_pkg::ST_DRIVE]   = drive_r;
         regs.rdata[lpc_pkg::ST_TXD]     = txd_in;
      end
   end

endmodule : lpc_top

// ==== bench/lpc_top_sva.sv ====
`timescale 1ns/1ps
module lpc_top_chk (
   input wire logic        sys_clk,
   input wire logic        rst_n,
   input wire logic        hsel,
   input wire logic [1:0]  htrans,
   input wire logic        hready,
   input wire logic        hreadyout,
   input wire logic        hresp,
   input wire logic [31:0] hrdata,
   input wire logic        overtemp_pin,
   input wire logic        lin_drive_dominant,
   input wire logic        phy_enable,
   input wire logic [1:0]  slew_mode,
   input wire logic        irq
);
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!rst_n);
   ahb_answer_a: assert property (hsel && htrans[1] && hready |=> !hreadyout ##1 hreadyout)
      else $error("transfer not answered after one wait state");
   one_wait_a: assert property (!hreadyout |=> hreadyout)
      else $error("wait state longer than one cycle");
   okay_resp_a: assert property (!hresp)
      else $error("response not OKAY");
   rdata_hold_a: assert property ($past(hreadyout) |-> $stable(hrdata))
      else $error("read data changed outside a read completion");
   // Async reset may land only at the first edge, so look from the second
   reset_state_a: assert property (disable iff (1'b0) !rst_n [*2] |->
      slew_mode == 2'h0 && !lin_drive_dominant && !irq && !phy_enable)
      else $error("outputs not at reset state");
   slew_legal_a: assert property (slew_mode != 2'h3)
      else $error("slew code 11 not mapped to normal");
   enable_gate_a: assert property (!phy_enable && !$past(phy_enable) |-> !lin_drive_dominant)
      else $error("bus driven while module disabled");
   // Two sync flops, shutdown latch and drive flop: six cycles covers them
   overtemp_off_a: assert property (overtemp_pin [*6] |-> !lin_drive_dominant)
      else $error("driver active during over-temperature");
endmodule : lpc_top_chk

bind lpc_top lpc_top_chk chk_u (
   .sys_clk(sys_clk),
   .rst_n(rst_n),
   .hsel(hsel),
   .htrans(htrans),
   .hready(hready),
   .hreadyout(hreadyout),
   .hresp(hresp),
   .hrdata(hrdata),
   .overtemp_pin(overtemp_pin),
   .lin_drive_dominant(lin_drive_dominant),
   .phy_enable(phy_enable),
   .slew_mode(slew_mode),
   .irq(irq)
);

// ==== bench/lpc_lin_node.sv ====
`timescale 1ns/1ps
// The pull-up leaves the line recessive unless some node pulls it down
module lpc_lin_node (
   input  wire logic drive_dominant,
   input  wire logic node_dominant,
   output logic      rx_level
);
   assign rx_level = !(drive_dominant || node_dominant);
endmodule : lpc_lin_node

// ==== bench/lpc_top_tb.sv ====
`timescale 1ns/1ps
module lpc_top_tb;
   localparam logic [7:0] CT = lpc_pkg::ADDR_CTRL;
   localparam logic [7:0] ST = lpc_pkg::ADDR_IRQ_STAT;
   localparam logic [7:0] MK = lpc_pkg::ADDR_IRQ_MASK;
   logic        sys_clk = 1'b0;
   logic        rst_n = 1'b0;
   logic        hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0]  htrans = 2'h0;
   logic        hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic        txd_in = 1'b1;
   logic        overtemp_pin = 1'b0;
   logic        undervoltage_pin = 1'b0;
   logic        node_dom = 1'b0;
   logic        hreadyout;
   logic        hresp;
   logic [31:0] hrdata;
   logic        rx_pin;
   logic        drive;
   logic        phy_enable;
   logic [1:0]  slew_mode;
   logic        irq;
   logic [31:0] rd;
   int          miscompares = 0;
   int          comparisons = 0;

   always #10 sys_clk = ~sys_clk;

   lpc_top dut_u (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .hsel(hsel),
      .haddr(haddr),
      .htrans(htrans),
      .hwrite(hwrite),
      .hwdata(hwdata),
      .hready(hreadyout),
      .hreadyout(hreadyout),
      .hresp(hresp),
      .hrdata(hrdata),
      .txd_in(txd_in),
      .rx_pin(rx_pin),
      .overtemp_pin(overtemp_pin),
      .undervoltage_pin(undervoltage_pin),
      .lin_drive_dominant(drive),
      .phy_enable(phy_enable),
      .slew_mode(slew_mode),
      .irq(irq)
   );

   lpc_lin_node node_u (
      .drive_dominant(drive),
      .node_dominant(node_dom),
      .rx_level(rx_pin)
   );

   task automatic complete_run;
      if (miscompares == 0 && comparisons > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : complete_run

   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      comparisons++;
      if (s !== e) begin
         miscompares++;
         $display("[FAIL] %0t ns: seen %h expected %h", $time, s, e);
      end
   endtask : chk

   task automatic wait_rdy;
      int n;
      n = 0;
      do begin
         @(posedge sys_clk);
         n++;
      end while (hreadyout !== 1'b1 && n < 20);
      chk(32'(n < 20), 32'h1);
   endtask : wait_rdy

   // Address phase held until taken, then data phase held until ready
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      hwrite <= w;
      htrans <= 2'h2;
      wait_rdy();
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      wait_rdy();
      rd = hrdata;
   endtask : xfer

   // Pins pass a two-flop sync, so give them six cycles to settle
   task automatic setp(input logic t, input logic o, input logic u);
      @(posedge sys_clk);
      txd_in <= t;
      overtemp_pin <= o;
      undervoltage_pin <= u;
      repeat (6) @(posedge sys_clk);
   endtask : setp

   function automatic logic [31:0] cv(input logic ie, input logic oc, input logic rx, input logic f,
                                      input logic lv, input logic en, input logic [1:0] s);
      return {24'h0, ie, oc, rx, f, lv, en, s};
   endfunction : cv

   task automatic t_reset;
      xfer(1'b0, CT, 32'h0);
      chk(rd, 32'h20);
      xfer(1'b1, 8'h10, 32'hff);
      xfer(1'b0, 8'h10, 32'h0);
      chk(rd, 32'h0);
      xfer(1'b0, MK, 32'h0);
      chk(rd, 32'h0);
      xfer(1'b0, lpc_pkg::ADDR_STATE, 32'h0);
      chk(rd, 32'h8);
   endtask : t_reset

   task automatic t_slew;
      for (int i = 0; i < 4; i++) begin
         xfer(1'b1, CT, cv(1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 2'(i)));
         @(posedge sys_clk);
         chk(32'(slew_mode), (i == 3) ? 32'h0 : 32'(i));
         chk(32'(phy_enable), 32'h1);
         xfer(1'b0, CT, 32'h0);
         chk(rd, cv(1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 2'(i)));
      end
   endtask : t_slew

   task automatic t_drive;
      xfer(1'b1, CT, cv(1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 2'h0));
      setp(1'b1, 1'b0, 1'b0);
      chk(32'(drive), 32'h0);
      xfer(1'b1, CT, cv(1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 2'h0));
      setp(1'b1, 1'b0, 1'b0);
      chk(32'(drive), 32'h1);
      xfer(1'b0, CT, 32'h0);
      chk(rd, cv(1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 2'h0));
      xfer(1'b1, CT, cv(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 2'h0));
      setp(1'b0, 1'b0, 1'b0);
      chk(32'(drive), 32'h1);
      setp(1'b1, 1'b0, 1'b0);
      chk(32'(drive), 32'h0);
      node_dom <= 1'b1;
      repeat (2) @(posedge sys_clk);
      xfer(1'b0, CT, 32'h0);
      chk(rd, cv(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 2'h0));
      node_dom <= 1'b0;
   endtask : t_drive

   task automatic t_overtemp;
      xfer(1'b1, MK, 32'h1);
      xfer(1'b1, CT, cv(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 2'h0));
      setp(1'b0, 1'b1, 1'b0);
      chk(32'(drive), 32'h0);
      chk(32'(irq), 32'h1);
      xfer(1'b0, CT, 32'h0);
      chk(rd, cv(1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 2'h0));
      setp(1'b0, 1'b1, 1'b0);
      chk(32'(irq), 32'h0);
      setp(1'b0, 1'b0, 1'b0);
      chk(32'(drive), 32'h0);
      setp(1'b1, 1'b0, 1'b0);
      setp(1'b0, 1'b0, 1'b0);
      chk(32'(drive), 32'h1);
      xfer(1'b0, ST, 32'h0);
      chk(rd, 32'h4);
      chk(32'(irq), 32'h0);
      xfer(1'b1, ST, 32'h4);
      xfer(1'b0, ST, 32'h0);
      chk(rd, 32'h0);
      setp(1'b1, 1'b1, 1'b0);
      chk(32'(irq), 32'h1);
      xfer(1'b0, CT, 32'h0);
      setp(1'b1, 1'b0, 1'b0);
      chk(32'(irq), 32'h0);
   endtask : t_overtemp

   task automatic t_uv;
      xfer(1'b1, ST, 32'h7);
      xfer(1'b1, CT, cv(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 2'h0));
      setp(1'b0, 1'b0, 1'b1);
      chk(32'(drive), 32'h1);
      setp(1'b1, 1'b0, 1'b1);
      setp(1'b0, 1'b0, 1'b1);
      chk(32'(drive), 32'h0);
      setp(1'b0, 1'b0, 1'b0);
      chk(32'(drive), 32'h0);
      setp(1'b1, 1'b0, 1'b0);
      setp(1'b0, 1'b0, 1'b0);
      chk(32'(drive), 32'h1);
      xfer(1'b0, ST, 32'h0);
      chk(rd & 32'h2, 32'h2);
      xfer(1'b1, CT, cv(1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 2'h0));
      setp(1'b1, 1'b0, 1'b1);
      setp(1'b0, 1'b0, 1'b1);
      chk(32'(drive), 32'h1);
      setp(1'b1, 1'b0, 1'b0);
   endtask : t_uv

   initial begin
      #100000;
      miscompares++;
      complete_run();
   end

   initial begin
      repeat (2) @(posedge sys_clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge sys_clk);
      t_reset();
      t_slew();
      t_drive();
      t_overtemp();
      t_uv();
      complete_run();
   end
endmodule : lpc_top_tb
